// file: src/sbsc_ctl.sv
// command decode, burst counter and data bus control of a burst sram
// assumes controller pins come from outside the clock domain, so each
// passes a two-stage synchroniser; the array itself sits outside
`timescale 1ns/1ps
module sbsc_ctl
   import sbsc_pkg::*;
(
   input  wire logic              I_CLK_SYS,
   input  wire logic              I_RST,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic              i_clk_en_n,
   input  wire logic              i_burst_advance_n_load,
   input  wire logic              i_write_n,
   input  wire logic [NBYTE-1:0]  i_byte_write_n,
   input  wire logic              i_select_a_n,
   input  wire logic              i_select_b,
   input  wire logic              i_select_c_n,
   input  wire logic              i_out_en_n,
   input  wire logic              i_sleep_req,
   input  wire logic              i_linear_order_n,
   input  wire logic              i_flow_through_n,
   input  wire logic              i_drive_strength_sel,
   input  wire logic [DATA_W-1:0] i_dq,
   input  wire logic [DATA_W-1:0] i_mem_rdata,
   output logic      [DATA_W-1:0] o_dq,
   output logic      [DATA_W-1:0] o_dq_oe,
   output logic      [ADDR_W-1:0] o_mem_addr,
   output logic                   o_mem_rd,
   output logic                   o_mem_wr,
   output logic      [NBYTE-1:0]  o_mem_be,
   output logic      [DATA_W-1:0] o_mem_wdata,
   output logic                   o_high_drive
);
   localparam int NIN = ADDR_W + NBYTE + 10 + DATA_W;

   logic [NIN-1:0] sync1_r, sync2_r;
   logic [NIN-1:0] pins;
   assign pins = {i_addr, i_byte_write_n, i_clk_en_n,
                  i_burst_advance_n_load, i_write_n, i_select_a_n,
                  i_select_b, i_select_c_n, i_out_en_n, i_sleep_req,
                  i_linear_order_n, i_flow_through_n, i_dq};
   logic [DATA_W-1:0] s_dq;
   logic [ADDR_W-1:0] s_addr;
   logic [NBYTE-1:0]  s_bw_n;
   logic s_cke_n, s_adv, s_w_n, s_e1_n, s_e2, s_e3_n;
   logic s_oe_n, s_sleep, s_lbo_n, s_ft_n;
   assign {s_addr, s_bw_n, s_cke_n, s_adv, s_w_n, s_e1_n, s_e2, s_e3_n,
           s_oe_n, s_sleep, s_lbo_n, s_ft_n, s_dq} = sync2_r;

   // state
   sbsc_state_t       st_r, st_nxt;
   logic [ADDR_W-1:0] base_r, base_nxt;
   logic [1:0]        cnt_r, cnt_nxt;
   // write pipe, two slots so pipelined mode can take data two edges later
   logic [1:0]        wv_r, wv_nxt;
   logic [ADDR_W-1:0] wa0_r, wa0_nxt, wa1_r, wa1_nxt;
   logic [NBYTE-1:0]  wb0_r, wb0_nxt, wb1_r, wb1_nxt;
   // read pipe
   logic [1:0]        rv_r, rv_nxt;
   logic [DATA_W-1:0] rq_r, rq_nxt;
   // outputs
   logic [DATA_W-1:0] dq_r, dq_nxt, oe_r, oe_nxt;
   logic [ADDR_W-1:0] ma_r, ma_nxt;
   logic              mrd_r, mrd_nxt, mwr_r, mwr_nxt;
   logic [NBYTE-1:0]  mbe_r, mbe_nxt;
   logic [DATA_W-1:0] mwd_r, mwd_nxt;
   logic              hd_r;
   // drive select strap crosses in through its own two flops
   logic              ds1_r, ds2_r;
   // posted array writes: a read owns the array port in its cycle, so write
   // data that lands then waits here; two entries cover the pipelined lag
   logic [1:0]        pw_cnt_r, pw_cnt_nxt, pw_n;
   logic [ADDR_W-1:0] pwa0_r, pwa0_nxt, pwa1_r, pwa1_nxt;
   logic [NBYTE-1:0]  pwb0_r, pwb0_nxt, pwb1_r, pwb1_nxt;
   logic [DATA_W-1:0] pwd0_r, pwd0_nxt, pwd1_r, pwd1_nxt;
   logic              wcap, pop;
   logic [ADDR_W-1:0] cap_a;
   logic [NBYTE-1:0]  cap_b;

   logic run, sel, any_bw, cont, ld_rd, ld_wr, ld_ds, go_rd, go_wr;
   logic [ADDR_W-1:0] acc_addr;
   logic [1:0]        cnt_inc;

   always_comb begin
      // sleep and clock enable both freeze the edge
      run     = !s_cke_n && !s_sleep;
      sel     = !s_e1_n && s_e2 && !s_e3_n;
      any_bw  = |(~s_bw_n);
      cont    = run && s_adv && (st_r != SBSC_DESEL);
      ld_rd   = run && !s_adv && sel && s_w_n;
      ld_wr   = run && !s_adv && sel && !s_w_n;
      ld_ds   = run && !s_adv && !sel;
      cnt_inc = 2'(cnt_r + 2'b01);
      acc_addr = ADDR_W'(s_addr);
      if (cont) begin
         acc_addr = {base_r[ADDR_W-1:2],
                     sbsc_step(base_r[1:0], cnt_inc, s_lbo_n)};
      end
      go_rd = ld_rd || (cont && st_r == SBSC_READ);
      go_wr = (ld_wr || (cont && st_r == SBSC_WRITE)) && any_bw;
      st_nxt   = st_r;
      base_nxt = base_r;
      cnt_nxt  = cnt_r;
      if (ld_rd || ld_wr) begin
         // a write load with no byte enables acts as a deselect
         if (ld_rd) begin
            st_nxt = SBSC_READ;
         end else if (any_bw) begin
            st_nxt = SBSC_WRITE;
         end else begin
            st_nxt = SBSC_DESEL;
         end
         base_nxt = s_addr;
         cnt_nxt  = 2'b00;
      end else if (ld_ds) begin
         st_nxt = SBSC_DESEL;
      end else if (cont) begin
         cnt_nxt = cnt_inc;
      end
      // write pipe: slot0 takes data next edge (flow), slot1 one later
      wv_nxt  = wv_r;
      wa0_nxt = wa0_r;
      wa1_nxt = wa1_r;
      wb0_nxt = wb0_r;
      wb1_nxt = wb1_r;
      mwr_nxt = 1'b0;
      mrd_nxt = 1'b0;
      ma_nxt  = ma_r;
      mbe_nxt = mbe_r;
      mwd_nxt = mwd_r;
      pwa0_nxt = pwa0_r;
      pwa1_nxt = pwa1_r;
      pwb0_nxt = pwb0_r;
      pwb1_nxt = pwb1_r;
      pwd0_nxt = pwd0_r;
      pwd1_nxt = pwd1_r;
      wcap  = run && (s_ft_n ? wv_r[1] : wv_r[0]);
      cap_a = s_ft_n ? wa1_r : wa0_r;
      cap_b = s_ft_n ? wb1_r : wb0_r;
      pop   = run && !go_rd && (pw_cnt_r != 2'b00 || wcap);
      pw_n  = pw_cnt_r;
      if (run) begin
         wv_nxt  = {wv_r[0], go_wr};
         wa0_nxt = acc_addr;
         wb0_nxt = ~s_bw_n;
         wa1_nxt = wa0_r;
         wb1_nxt = wb0_r;
         if (go_rd) begin
            mrd_nxt = 1'b1;
            ma_nxt  = acc_addr;
         end
      end
      // oldest posted write first; with none posted the new data goes through
      if (pop) begin
         mwr_nxt = 1'b1;
         if (pw_cnt_r != 2'b00) begin
            ma_nxt   = pwa0_r;
            mbe_nxt  = pwb0_r;
            mwd_nxt  = pwd0_r;
            pwa0_nxt = pwa1_r;
            pwb0_nxt = pwb1_r;
            pwd0_nxt = pwd1_r;
            pw_n     = 2'(pw_cnt_r - 2'b01);
         end else begin
            ma_nxt  = cap_a;
            mbe_nxt = cap_b;
            mwd_nxt = s_dq;
         end
      end
      if (wcap && !(pop && pw_cnt_r == 2'b00)) begin
         if (pw_n == 2'b00) begin
            pwa0_nxt = cap_a;
            pwb0_nxt = cap_b;
            pwd0_nxt = s_dq;
         end else begin
            pwa1_nxt = cap_a;
            pwb1_nxt = cap_b;
            pwd1_nxt = s_dq;
         end
         pw_n = 2'(pw_n + 2'b01);
      end
      pw_cnt_nxt = pw_n;
      // read pipe: data from the array is registered once more when pipelined
      rv_nxt = rv_r;
      rq_nxt = rq_r;
      if (run) begin
         rv_nxt = {rv_r[0], go_rd};
         rq_nxt = i_mem_rdata;
      end
      // on a stall rv_r holds, so a pipelined read keeps driving
      dq_nxt = s_ft_n ? rq_r : i_mem_rdata;
      oe_nxt = '0;
      if ((s_ft_n ? rv_r[1] : rv_r[0]) && !s_oe_n && !s_sleep) begin
         oe_nxt = '1;
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      if (I_RST) begin
         st_r <= SBSC_DESEL;
         base_r <= '0;
         cnt_r <= '0;
         wv_r <= '0;
         wa0_r <= '0;
         wa1_r <= '0;
         wb0_r <= '0;
         wb1_r <= '0;
         rv_r <= '0;
         rq_r <= '0;
         dq_r <= '0;
         oe_r <= '0;
         ma_r <= '0;
         mrd_r <= 1'b0;
         mwr_r <= 1'b0;
         mbe_r <= '0;
         mwd_r <= '0;
         hd_r <= 1'b0;
         pw_cnt_r <= 2'b00;
         pwa0_r <= '0;
         pwa1_r <= '0;
         pwb0_r <= '0;
         pwb1_r <= '0;
         pwd0_r <= '0;
         pwd1_r <= '0;
      end else begin
         st_r <= st_nxt;
         base_r <= base_nxt;
         cnt_r <= cnt_nxt;
         wv_r <= wv_nxt;
         wa0_r <= wa0_nxt;
         wa1_r <= wa1_nxt;
         wb0_r <= wb0_nxt;
         wb1_r <= wb1_nxt;
         rv_r <= rv_nxt;
         rq_r <= rq_nxt;
         dq_r <= dq_nxt;
         oe_r <= oe_nxt;
         ma_r <= ma_nxt;
         mrd_r <= mrd_nxt;
         mwr_r <= mwr_nxt;
         mbe_r <= mbe_nxt;
         mwd_r <= mwd_nxt;
         hd_r <= !s_sleep ? !ds2_r : hd_r;
         pw_cnt_r <= pw_cnt_nxt;
         pwa0_r <= pwa0_nxt;
         pwa1_r <= pwa1_nxt;
         pwb0_r <= pwb0_nxt;
         pwb1_r <= pwb1_nxt;
         pwd0_r <= pwd0_nxt;
         pwd1_r <= pwd1_nxt;
      end
   end

   // drive select is a static strap, so its flops need no reset
   always_ff @(posedge I_CLK_SYS) begin
      ds1_r <= i_drive_strength_sel;
      ds2_r <= ds1_r;
   end

   assign o_dq         = dq_r;
   assign o_dq_oe      = oe_r;
   assign o_mem_addr   = ma_r;
   assign o_mem_rd     = mrd_r;
   assign o_mem_wr     = mwr_r;
   assign o_mem_be     = mbe_r;
   assign o_mem_wdata  = mwd_r;
   assign o_high_drive = hd_r;

   a_stall_freeze: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      !run |=> ($stable(st_r) && $stable(cnt_r)))
      else $error("state moved on a frozen edge");
   a_cnt_step: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      cont |=> cnt_r == 2'($past(cnt_r) + 2'b01))
      else $error("counter did not step");
   a_load_clr: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      (ld_rd || ld_wr) |=> (cnt_r == 2'b00 && base_r == $past(s_addr)))
      else $error("load did not capture address");
   a_desel_off: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      ld_ds |=> st_r == SBSC_DESEL)
      else $error("deselect missed");
   a_noop_write: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      (ld_wr && !any_bw) |-> !go_wr)
      else $error("write with no bytes");
   a_oe_read: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      s_oe_n |=> o_dq_oe == '0)
      else $error("bus driven with output enable high");
   a_write_quiet: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      wcap |=> o_dq_oe == '0)
      else $error("bus driven during write");
   a_abort_cont: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      (cont && st_r == SBSC_WRITE && !any_bw) |-> !go_wr)
      else $error("aborted write went ahead");
   a_desel_stay: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      (run && s_adv && st_r == SBSC_DESEL) |=>
         (st_r == SBSC_DESEL && !o_mem_rd))
      else $error("continue left deselect");
   a_cnt_wrap: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      (cont && cnt_r == 2'b11) |=> cnt_r == 2'b00)
      else $error("counter did not wrap");
   a_stall_hold: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      (s_cke_n && !s_sleep && !s_oe_n && s_ft_n && rv_r[1]) |=>
         o_dq_oe == '1)
      else $error("stalled pipelined read dropped the bus");
   a_flow_read: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      (!s_ft_n && rv_r[0] && !s_oe_n && !s_sleep) |=> o_dq_oe == '1)
      else $error("flow-through read not driven");
   a_post_room: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      (wcap && pw_cnt_r == 2'b10) |-> pop)
      else $error("posted write overflow");
   a_sleep_off: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      s_sleep |=> (o_dq_oe == '0 && !o_mem_wr))
      else $error("active in sleep");
endmodule

// file: src/sbsc_pkg.sv
// constants and types for the synchronous burst sram command block
// assumes one 50 MHz system clock and a synchronous active-high reset
//
// Summary of operation
// - new address, read burst when enabled, selected, advance low, write high
// - new address, write burst when selected, write low, some byte enable low
// - write with no byte enable low is a no-op
// - advance high continues the current burst, ignoring write and selects
// - continued write stores enabled bytes, aborts with bus off if none
// - counter steps on every continue cycle of a read or write burst, not while deselected
// - advance low with any select inactive deselects, bus off
// - continue after deselect stays deselected, bus off
// - output enable high makes reads silent, bus off
// - drivers turn off during writes on their own
// - clock enable high freezes everything for that edge; output enable and the drive pin still act
// - stall keeps a pipelined read driving, a write stays off
// - pins sampled on clock; output enable and sleep also take effect only on clock edges
// - all outputs off while powering up (reset)
// - advance low loads the start address, high uses the counter
// - two-bit burst counter on the low address bits
// - counter returns to the loaded value on the fifth clock
// - order pin low linear, high interleaved
// - linear order adds one modulo four
// - flow pin low flow-through, high pipelined; drive pin default low drive
// - sleep high puts the device in standby, inputs ignored, bus off
// - drive pin low nominal drive, high low drive
// - pipelined: read data two edges after address, write data third edge
// - flow-through: read data one edge after address, write data second edge
package sbsc_pkg;
   localparam int ADDR_W     = 20;
   localparam int DATA_W     = 36;
   localparam int NBYTE      = 4;
   localparam int BYTE_W     = 9;
   localparam int SYNC_DEPTH = 2;

   typedef enum logic [1:0] {
      SBSC_DESEL = 2'b00,
      SBSC_READ  = 2'b01,
      SBSC_WRITE = 2'b11
   } sbsc_state_t;

   // next burst offset; interleaved order is an xor of the step count
   function automatic logic [1:0] sbsc_step(input logic [1:0] start,
                                            input logic [1:0] cnt,
                                            input logic       inter);
      sbsc_step = inter ? (start ^ cnt) : 2'(start + cnt);
   endfunction
endpackage

// file: test/sbsc_mem_model.sv
// array stand-in: read data is a fixed pattern of the address
// assumes reads are combinational from the array address port
`timescale 1ns/1ps
module sbsc_mem_model
   import sbsc_pkg::*;
(
   input  wire logic [ADDR_W-1:0] i_addr,
   output logic      [DATA_W-1:0] o_rdata
);
   // stored contents are not kept, so read data never depends on write timing
   assign o_rdata = {16'h5A3C, i_addr};
endmodule

// file: test/sbsc_ctl_tb.sv
// random command bench: burst address model compared with array accesses
// assumes the array model answers reads from the address pattern
`timescale 1ns/1ps
module sbsc_ctl_tb;
   import sbsc_pkg::*;
   logic I_CLK_SYS = 0, I_RST = 1, ce_n = 1, burst_advance_n_load = 0, w_n = 1;
   logic sa_n = 1, sb = 0, sc_n = 1, lo_n = 0, ft_n = 1, ds = 0;
   logic [ADDR_W-1:0] a = '0;
   logic [NBYTE-1:0]  bw = '1;
   logic [DATA_W-1:0] dq = '0, o_dq, oe, rdata, wd;
   logic [ADDR_W-1:0] ma;
   logic              rd, wr, hd;
   logic [NBYTE-1:0]  be;
   int n_fail = 0, checked = 0, cyc = 0, seed = 19, st = 0, cnt = 0;
   logic [ADDR_W-1:0] s0;
   logic oe_n = 0, zz = 0;
   int pi = 0;
   logic [35:0] dh[$];
   int wi[$];
   logic [23:0] rq[$], wq[$];
   bit seen[logic [19:0]];
   always #10 I_CLK_SYS = ~I_CLK_SYS;
   sbsc_ctl DUT (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .i_addr(a),
      .i_clk_en_n(ce_n), .i_burst_advance_n_load(burst_advance_n_load), .i_write_n(w_n),
      .i_byte_write_n(bw), .i_select_a_n(sa_n), .i_select_b(sb),
      .i_select_c_n(sc_n), .i_out_en_n(oe_n), .i_sleep_req(zz),
      .i_linear_order_n(lo_n), .i_flow_through_n(ft_n),
      .i_drive_strength_sel(ds), .i_dq(dq), .i_mem_rdata(rdata),
      .o_dq(o_dq), .o_dq_oe(oe), .o_mem_addr(ma), .o_mem_rd(rd),
      .o_mem_wr(wr), .o_mem_be(be), .o_mem_wdata(wd), .o_high_drive(hd));
   sbsc_mem_model mem (.i_addr(ma), .o_rdata(rdata));
   task automatic print_verdict();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [35:0] e, g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one pin cycle; the model mirrors the documented command decode
   task automatic put(input logic c, v, w, input logic [3:0] b, input bit sel);
      logic [1:0] lo;
      @(posedge I_CLK_SYS);
      #1;
      ce_n = c; burst_advance_n_load = v; w_n = w; bw = b; a = $random(seed);
      dq = 36'({$random(seed), $random(seed)});
      oe_n = ({$random(seed)} % 4 == 0);
      {sa_n, sb, sc_n} = sel ? 3'b010 : 3'b010 ^ (3'b001 << {$random(seed)} % 3);
      if (c) return;
      dh.push_back(dq);
      pi++;
      if (!v) begin
         cnt = 0;
         s0 = a;
         if (!sel) st = 0;
         else if (w) begin st = 1; rq.push_back(a); seen[a] = 1; end
         else if (b != 4'hF) begin
            st = 2;
            wq.push_back({~b, a});
            wi.push_back(pi - 1 + (ft_n ? 2 : 1));
         end
         else st = 0;
      end else if (st != 0) begin
         cnt++;
         lo = lo_n ? s0[1:0] ^ 2'(cnt) : s0[1:0] + 2'(cnt);
         if (st == 1) begin rq.push_back({s0[19:2], lo}); seen[{s0[19:2], lo}] = 1; end
         else if (b != 4'hF) begin
            wq.push_back({~b, s0[19:2], lo});
            wi.push_back(pi - 1 + (ft_n ? 2 : 1));
         end
      end
   endtask
   always @(posedge I_CLK_SYS) begin
      cyc++;
      if (cyc == 20000) begin n_fail++; print_verdict(); end
      if (I_RST && cyc > 3) cmp("oe reset", '0, oe);
      if (!I_RST && rd === 1'b1) begin
         if (rq.size() == 0) cmp("extra read", 0, 1);
         else cmp("read addr", 36'(rq.pop_front()), 36'(ma));
      end
      if (!I_RST && wr === 1'b1) begin
         if (wq.size() == 0) cmp("extra write", 0, 1);
         else begin
            cmp("write addr", 36'(wq.pop_front()), 36'({be, ma}));
            cmp("write data", dh[wi.pop_front()], wd);
         end
      end
      if (!I_RST && oe !== '0) begin
         cmp("oe all", '1, oe);
         cmp("read data", {16'h5A3C, o_dq[19:0]}, o_dq);
         cmp("data addr", 1, 36'(seen.exists(o_dq[19:0])));
      end
   end
   initial begin
      int op, n;
      logic [3:0] r;
      repeat (16) @(posedge I_CLK_SYS);
      #1 I_RST = 0;
      for (int m = 0; m < 4; m++) begin
         lo_n = m[0];
         ft_n = m[1];
         ds = $random(seed);
         repeat (6) put(0, 0, 1, 4'hF, 0);
         for (int k = 0; k < 8; k++) begin
            op = {$random(seed)} % 4;
            r = $random(seed) | 4'h1;
            put(0, 0, op[0], op == 2 ? 4'hF : ~r, op != 3);
            n = {$random(seed)} % 6;
            for (int j = 0; j < n; j++) begin
               if ({$random(seed)} % 3 == 0) put(1, $random(seed), 0, 0, 0);
               r = $random(seed);
               put(0, 1, $random(seed), ({$random(seed)} % 3 == 0) ? 4'hF : r, 0);
            end
         end
         repeat (4) put(0, 0, 1, 4'hF, 0);
         zz = 1;
         repeat (3) put(0, 0, 1, 4'hF, 0);
         zz = 0;
         repeat (6) put(0, 0, 1, 4'hF, 0);
         cmp("drive", 36'(!ds), 36'(hd));
         cmp("queues", 0, 36'(rq.size() + wq.size()));
      end
      print_verdict();
   end
endmodule
